// file: shared/pst_pkg.sv
// Package with register map, field layout and carrier types of the readout.
package pst_pkg;
   // ---------------------------------------------------------------
   // Register offsets
   // ---------------------------------------------------------------
   localparam logic [7:0] OFF_TEMP_CTRL = 8'h1E;
   localparam logic [7:0] OFF_STATUS = 8'h1F;
   localparam logic [7:0] OFF_RSVD_A = 8'h20;
   localparam logic [7:0] OFF_TEMP_READ = 8'h21;
   localparam logic [7:0] OFF_RSVD_B = 8'h22;
   // ---------------------------------------------------------------
   // Field positions and reset values
   // ---------------------------------------------------------------
   localparam int DATA_W = 24;
   localparam int BIT_SENS_EN = 0;
   localparam int BIT_LOCK = 0;
   localparam int BIT_OVF_LO = 1;
   localparam int OVF_W = 3;
   localparam int BIT_BUSY = 5;
   localparam int TEMP_W = 7;
   localparam logic [23:0] RST_TEMP_CTRL = 24'h000000;
   localparam logic [23:0] RST_STATUS = 24'h000000;
   localparam logic [23:0] RST_RSVD_A = 24'h000020;
   localparam logic [23:0] RST_TEMP_READ = 24'h000000;
   localparam logic [23:0] RST_RSVD_B = 24'h000000;
   localparam logic [6:0] TEMP_MAX_CODE = 7'h07;
   // Sensor raw word is degrees C offset by 40, times 2 (half-degree lsb).
   localparam int RAW_W = 10;
   localparam logic [9:0] STEP_HALF_DEG = 10'h023;

   typedef struct packed {
      logic locked;
      logic [2:0] overflow;
      logic sweep_running;
      logic sweep_enabled;
   } pst_pll_state_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [23:0] wdata;
      logic wr;
      logic rd;
   } pst_reg_req_t;
endpackage

// file: design/pst_temp_quant.sv
// Temperature quantizer: raw sensor word to seven-bit registered code.
`timescale 1ns/1ps
module pst_temp_quant
(
   input wire logic mclk,
   input wire logic reset,
   input wire logic sample,
   input wire logic [9:0] raw_half_deg,
   output logic [6:0] code_r
);
   logic [6:0] code_nxt;

   // Counting steps avoids a divider; seven compares cost less area.
   always_comb
   begin
      code_nxt = 7'h00;
      for (int k = 1; k <= int'(pst_pkg::TEMP_MAX_CODE); k++)
      begin
         if (raw_half_deg >= 10'(k) * pst_pkg::STEP_HALF_DEG)
         begin
            code_nxt = 7'(k);
         end
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         code_r <= 7'h00;
      end
      else if (sample)
      begin
         code_r <= code_nxt;
      end
   end

   property p_sat_top;
      @(posedge mclk) disable iff (reset)
      (sample && raw_half_deg >= 10'h0F5) |=> code_r == 7'h07;
   endproperty
   a_sat_top: assert property (p_sat_top)
      else $error("temperature code not saturated high");

   property p_floor;
      @(posedge mclk) disable iff (reset)
      (sample && raw_half_deg < 10'h023) |=> code_r == 7'h00;
   endproperty
   a_floor: assert property (p_floor)
      else $error("temperature code not zero below first step");
endmodule // pst_temp_quant

// file: design/pst_readout.sv
// Status and temperature readout register bank of the synthesizer.
`timescale 1ns/1ps
module pst_readout
(
   input wire logic mclk,
   input wire logic reset,
   input wire pst_pkg::pst_reg_req_t req,
   output logic [23:0] rdata_r,
   input wire pst_pkg::pst_pll_state_t pll,
   input wire logic sensor_strobe,
   input wire logic [9:0] sensor_raw,
   output logic sensor_power_r,
   output logic temp_valid_r
);
   // ---------------------------------------------------------------
   // Input synchronisers
   // ---------------------------------------------------------------
   logic [5:0] pll_s1_r;
   logic [5:0] pll_s2_r;
   logic [10:0] sen_s1_r;
   logic [10:0] sen_s2_r;
   logic strobe_d_r;
   logic sample;
   logic ctrl_en_r;
   logic [2:0] ovf_r;
   logic [6:0] temp_code;

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         pll_s1_r <= 6'h00;
         pll_s2_r <= 6'h00;
         sen_s1_r <= 11'h000;
         sen_s2_r <= 11'h000;
         strobe_d_r <= 1'b0;
      end
      else
      begin
         pll_s1_r <= pll;
         pll_s2_r <= pll_s1_r;
         sen_s1_r <= {sensor_strobe, sensor_raw};
         sen_s2_r <= sen_s1_r;
         strobe_d_r <= sen_s2_r[10];
      end
   end

   // A reading is captured on the rising edge of the software strobe while the sensor enable bit is set.
   assign sample = sen_s2_r[10] && !strobe_d_r && ctrl_en_r;

   // ---------------------------------------------------------------
   // Control register
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         ctrl_en_r <= pst_pkg::RST_TEMP_CTRL[pst_pkg::BIT_SENS_EN];
      end
      else if (req.wr && req.addr == pst_pkg::OFF_TEMP_CTRL)
      begin
         ctrl_en_r <= req.wdata[pst_pkg::BIT_SENS_EN];
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         sensor_power_r <= 1'b0;
      end
      else
      begin
         sensor_power_r <= ctrl_en_r;
      end
   end

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         temp_valid_r <= 1'b0;
      end
      else if (!ctrl_en_r)
      begin
         temp_valid_r <= 1'b0;
      end
      else if (sample)
      begin
         temp_valid_r <= 1'b1;
      end
   end

   pst_temp_quant u_quant
   (
      .mclk(mclk),
      .reset(reset),
      .sample(sample),
      .raw_half_deg(sen_s2_r[9:0]),
      .code_r(temp_code)
   );

   // ---------------------------------------------------------------
   // Status word
   // ---------------------------------------------------------------
   logic locked_s;
   logic sweep_run_s;
   logic sweep_en_s;
   logic busy;
   assign locked_s = pll_s2_r[5];
   assign sweep_run_s = pll_s2_r[1];
   assign sweep_en_s = pll_s2_r[0];
   assign busy = sweep_run_s && sweep_en_s;

   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         ovf_r <= 3'h0;
      end
      else
      begin
         ovf_r <= pll_s2_r[4:2];
      end
   end

   // ---------------------------------------------------------------
   // Read port
   // ---------------------------------------------------------------
   always_ff @(posedge mclk or posedge reset)
   begin
      if (reset)
      begin
         rdata_r <= 24'h000000;
      end
      else if (req.rd)
      begin
         unique case (req.addr)
            pst_pkg::OFF_TEMP_CTRL:
               rdata_r <= {23'h000000, ctrl_en_r};
            pst_pkg::OFF_STATUS:
               rdata_r <= {18'h00000, busy, 1'b0, ovf_r, locked_s};
            pst_pkg::OFF_RSVD_A:
               rdata_r <= pst_pkg::RST_RSVD_A;
            pst_pkg::OFF_TEMP_READ:
               rdata_r <= {17'h00000, temp_code};
            pst_pkg::OFF_RSVD_B:
               rdata_r <= pst_pkg::RST_RSVD_B;
            default:
               rdata_r <= 24'h000000;
         endcase
      end
      else
      begin
         rdata_r <= 24'h000000;
      end
   end

   property p_power;
      @(posedge mclk) disable iff (reset)
      (req.wr && req.addr == pst_pkg::OFF_TEMP_CTRL)
         |=> ##1 sensor_power_r == $past(req.wdata[0], 2);
   endproperty
   a_power: assert property (p_power)
      else $error("sensor power does not follow enable");

   property p_lock;
      @(posedge mclk) disable iff (reset)
      (req.rd && req.addr == 8'h1F) |=> rdata_r[0] == $past(pll_s2_r[5]);
   endproperty
   a_lock: assert property (p_lock)
      else $error("lock bit misreported");

   property p_busy_off;
      @(posedge mclk) disable iff (reset)
      (req.rd && req.addr == 8'h1F && !pll_s2_r[0]) |=> rdata_r[5] == 1'b0;
   endproperty
   a_busy_off: assert property (p_busy_off)
      else $error("busy set while sweeper unused");

   property p_busy_on;
      @(posedge mclk) disable iff (reset)
      (req.rd && req.addr == 8'h1F && pll_s2_r[1] && pll_s2_r[0])
         |=> rdata_r[5];
   endproperty
   a_busy_on: assert property (p_busy_on)
      else $error("busy clear during ramp");

   property p_rsvd;
      @(posedge mclk) disable iff (reset)
      (req.rd && req.addr == 8'h20) |=> rdata_r == 24'h000020;
   endproperty
   a_rsvd: assert property (p_rsvd)
      else $error("reserved word wrong");

   property p_ovf;
      @(posedge mclk) disable iff (reset)
      (req.rd && req.addr == 8'h1F) |=> rdata_r[3:1] == $past(ovf_r);
   endproperty
   a_ovf: assert property (p_ovf)
      else $error("overflow bits misreported");

   property p_temp;
      @(posedge mclk) disable iff (reset)
      (req.rd && req.addr == 8'h21) |=> rdata_r[23:7] == 17'h00000;
   endproperty
   a_temp: assert property (p_temp)
      else $error("temperature upper bits not zero");

   property p_valid;
      @(posedge mclk) disable iff (reset)
      !ctrl_en_r |=> !temp_valid_r;
   endproperty
   a_valid: assert property (p_valid)
      else $error("reading valid without enable");
endmodule // pst_readout

// file: sim/tb_pll_status_temp_readout.sv
// Self-checking testbench of the status and temperature readout bank.
`timescale 1ns/1ps
module tb_pll_status_temp_readout;
   logic mclk = 1'b0;
   logic reset = 1'b1;
   pst_pkg::pst_reg_req_t req = '0;
   pst_pkg::pst_pll_state_t pll = '0;
   logic sensor_strobe = 1'b0;
   logic [9:0] sensor_raw = 10'h000;
   logic [23:0] rdata_r;
   logic sensor_power_r;
   logic temp_valid_r;
   logic [9:0] raws [6] = '{10'h000, 10'h022, 10'h023, 10'h0F4, 10'h0F5,
      10'h3FF};
   int fails = 0;
   int comparisons = 0;
   int q;

   always #2 mclk = ~mclk;

   pst_readout dut
   (
      .mclk(mclk),
      .reset(reset),
      .req(req),
      .rdata_r(rdata_r),
      .pll(pll),
      .sensor_strobe(sensor_strobe),
      .sensor_raw(sensor_raw),
      .sensor_power_r(sensor_power_r),
      .temp_valid_r(temp_valid_r)
   );

   // ---------------------------------------------------------------
   // Bus tasks and comparison
   // ---------------------------------------------------------------
   task automatic chk(input logic [23:0] g, input logic [23:0] e);
      comparisons++;
      if (g !== e)
      begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [23:0] d);
      @(posedge mclk);
      req.addr <= a;
      req.wdata <= d;
      req.wr <= 1'b1;
      @(posedge mclk);
      req.wr <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rdchk(input logic [7:0] a, input logic [23:0] e);
      @(posedge mclk);
      req.addr <= a;
      req.rd <= 1'b1;
      @(posedge mclk);
      req.rd <= 1'b0;
      #1;
      chk(rdata_r, e);
   endtask

   // The raw word is set well ahead so the synchronised copy has settled.
   task automatic sample(input logic [9:0] raw);
      @(posedge mclk);
      sensor_raw <= raw;
      repeat (4) @(posedge mclk);
      sensor_strobe <= 1'b1;
      repeat (3) @(posedge mclk);
      sensor_strobe <= 1'b0;
      repeat (8) @(posedge mclk);
   endtask

   task automatic print_verdict;
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // Tests
   // ---------------------------------------------------------------
   initial
   begin
      repeat (4) @(posedge mclk);
      reset <= 1'b0;
      #1;
      chk({23'h000000, sensor_power_r}, 24'h000000);
      rdchk(8'h1E, pst_pkg::RST_TEMP_CTRL);
      rdchk(8'h1F, pst_pkg::RST_STATUS);
      rdchk(8'h20, pst_pkg::RST_RSVD_A);
      rdchk(8'h21, pst_pkg::RST_TEMP_READ);
      rdchk(8'h22, pst_pkg::RST_RSVD_B);
      rdchk(8'h23, 24'h000000);
      $display("test reset values done");
      for (int a = 8'h1F; a <= 8'h22; a++)
         wr(8'(a), 24'hFFFFFF);
      rdchk(8'h1F, 24'h000000);
      rdchk(8'h20, 24'h000020);
      rdchk(8'h21, 24'h000000);
      rdchk(8'h22, 24'h000000);
      wr(8'h1E, 24'hFFFFFF);
      repeat (2) @(posedge mclk);
      #1;
      chk({23'h000000, sensor_power_r}, 24'h000001);
      rdchk(8'h1E, 24'h000001);
      $display("test write protection done");
      @(posedge mclk);
      pll <= '{1'b1, 3'b101, 1'b1, 1'b1};
      repeat (5) @(posedge mclk);
      rdchk(8'h1F, 24'h00002B);
      pll.sweep_running <= 1'b0;
      repeat (5) @(posedge mclk);
      rdchk(8'h1F, 24'h00000B);
      pll <= '{1'b0, 3'b000, 1'b1, 1'b0};
      repeat (5) @(posedge mclk);
      rdchk(8'h1F, 24'h000000);
      $display("test status done");
      foreach (raws[i])
      begin
         sample(raws[i]);
         q = raws[i] / 35;
         if (q > 7)
            q = 7;
         rdchk(8'h21, 24'(q));
      end
      chk({23'h000000, temp_valid_r}, 24'h000001);
      $display("test temperature done");
      wr(8'h1E, 24'h000000);
      repeat (2) @(posedge mclk);
      #1;
      chk({23'h000000, sensor_power_r}, 24'h000000);
      chk({23'h000000, temp_valid_r}, 24'h000000);
      sample(10'h000);
      rdchk(8'h21, 24'h000007);
      chk({23'h000000, temp_valid_r}, 24'h000000);
      $display("test sensor disable done");
      print_verdict();
   end

   // The whole run needs well under a thousand cycles.
   initial
   begin
      #20000;
      fails++;
      print_verdict();
   end
endmodule // tb_pll_status_temp_readout
